// ==== rtl/fir_defines.svh ====
// Behaviour
// [RULE1] An injected fault trigger is handled exactly like a detected fault of the same type.
// [RULE2] An injected trigger stays set until the power manager clears the injection request.
// [RULE3] A fault pulls the group fault lines as its propagation setting says and shuts the unit.
// [RULE4] A non-latching fault counts as cleared as soon as its trigger goes away.
// [RULE5] After a non-latching fault clears, the unit waits a 130 ms hiccup time, then restarts.
// [RULE6] Units of the group and system shut down by propagation restart along with the source.
// [RULE7] A latching fault keeps the output off after its trigger goes away.
// [RULE8] A latched fault is cleared by toggling the enable pin or by an off command.
// [RULE9] The one shared line carries both synchronisation timing and commands.
// [RULE10] Each unit signals and follows faults on the fault line of its assigned group.
// [RULE11] The power manager always reads a low group fault line as a fault indication.
`ifndef FIR_DEFINES_SVH
`define FIR_DEFINES_SVH

// Fault sources and their index in every fault vector
`define FIR_N_FAULT 4
`define FIR_FAULT_OC 0
`define FIR_FAULT_OV 1
`define FIR_FAULT_UV 2
`define FIR_FAULT_OVER_TEMPERATURE 3
`define FIR_GROUPS 4

// Timing
`define FIR_CLK_NS 8
`define FIR_HICCUP_MS 130
`define FIR_HICCUP_CYCLES ((`FIR_HICCUP_MS * 1000000) / `FIR_CLK_NS)
`define FIR_CNT_W 24
`define FIR_SYNC_MIN_NS 2000
`define FIR_SYNC_MIN_CYCLES ((`FIR_SYNC_MIN_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_BIT_NS 400
`define FIR_BIT_CYCLES (`FIR_BIT_NS / `FIR_CLK_NS)

// Command frame layout, first bit received ends up in the MSB
`define FIR_FRAME_BITS 10
`define FIR_ADDR_W 5
`define FIR_ADDR_LSB 5
`define FIR_OP_W 3
`define FIR_OP_LSB 2
`define FIR_ARG_W 2
`define FIR_ARG_LSB 0

// Reset values
`define FIR_INJ_RST 4'h0
`define FIR_SCOPE_RST 2'h0

`endif

// ==== rtl/fir_pkg.sv ====
package fir_pkg;

  typedef enum logic [2:0] {
    FIR_ST_OFF     = 3'b000,
    FIR_ST_RUN     = 3'b001,
    FIR_ST_FAULT   = 3'b010,
    FIR_ST_HICCUP  = 3'b011,
    FIR_ST_LATCHED = 3'b100
  } fir_state_e;

  typedef enum logic [2:0] {
    FIR_OP_NOP     = 3'b000,
    FIR_OP_ON      = 3'b001,
    FIR_OP_OFF     = 3'b010,
    FIR_OP_INJ_SET = 3'b011,
    FIR_OP_INJ_CLR = 3'b100
  } fir_op_e;

  // Propagation setting per fault; bit 0 group, bit 1 system
  typedef enum logic [1:0] {
    FIR_PROP_NONE   = 2'b00,
    FIR_PROP_GROUP  = 2'b01,
    FIR_PROP_SYSTEM = 2'b10
  } fir_prop_e;

endpackage

// ==== rtl/fir_sync_cmd_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fir_defines.svh"

module fir_sync_cmd_rx #(
  parameter int unsigned SYNC_MIN = `FIR_SYNC_MIN_CYCLES,
  parameter int unsigned BIT_CYCLES = `FIR_BIT_CYCLES,
  parameter int unsigned FRAME_BITS = `FIR_FRAME_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Shared line
  input wire logic line_i,
  // Recovered timing and commands
  output logic sync_tick_o,
  output logic cmd_valid_o,
  output logic [FRAME_BITS-1:0] cmd_frame_o
);
  localparam int unsigned LW = $clog2(SYNC_MIN + 1) + 1;
  localparam int unsigned PW = $clog2(BIT_CYCLES + 1) + 1;
  localparam int unsigned BW = $clog2(FRAME_BITS + 1) + 1;

  logic line_q_reg;
  logic [LW-1:0] low_cnt_reg;
  logic in_frame_reg;
  logic [PW-1:0] phase_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;

  // Long low only counts as sync between frames; data zeros are shorter than a frame
  wire rise = !line_q_reg && line_i;
  wire low_long = (low_cnt_reg >= LW'(SYNC_MIN));
  wire sync_hit = rise && low_long && !in_frame_reg; // [RULE9]
  wire sample = in_frame_reg && (phase_reg == '0);
  wire last_bit = sample && (bit_cnt_reg == BW'(FRAME_BITS - 1));
  wire [FRAME_BITS-1:0] shift_next = {shift_reg[FRAME_BITS-2:0], line_i};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_q_reg <= 1'b1;
      low_cnt_reg <= '0;
      in_frame_reg <= 1'b0;
      phase_reg <= '0;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      sync_tick_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_frame_o <= '0;
    end else if (ce_i) begin
      line_q_reg <= line_i;
      sync_tick_o <= sync_hit; // [RULE9]
      cmd_valid_o <= last_bit; // [RULE9]
      // Trailing data zeros must not run on into a false sync after the frame
      if (line_i || in_frame_reg) begin
        low_cnt_reg <= '0;
      end else if (!low_long) begin
        low_cnt_reg <= low_cnt_reg + LW'(1);
      end
      if (sync_hit) begin
        in_frame_reg <= 1'b1;
        phase_reg <= PW'(BIT_CYCLES / 2);
        bit_cnt_reg <= '0;
      end else if (sample) begin
        shift_reg <= shift_next;
        phase_reg <= PW'(BIT_CYCLES - 1);
        bit_cnt_reg <= bit_cnt_reg + BW'(1);
        if (last_bit) begin
          in_frame_reg <= 1'b0;
          cmd_frame_o <= shift_next;
        end
      end else if (in_frame_reg) begin
        phase_reg <= phase_reg - PW'(1);
      end
    end
  end

endmodule // fir_sync_cmd_rx

`default_nettype wire

// ==== rtl/fir_fault_inject_recovery.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fir_defines.svh"

module fir_fault_inject_recovery #(
  parameter int unsigned N_FAULT = `FIR_N_FAULT,
  parameter int unsigned GROUPS = `FIR_GROUPS,
  parameter int unsigned CNT_W = `FIR_CNT_W,
  parameter int unsigned HICCUP_CYCLES = `FIR_HICCUP_CYCLES,
  parameter int unsigned SYNC_MIN = `FIR_SYNC_MIN_CYCLES,
  parameter int unsigned BIT_CYCLES = `FIR_BIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Shared sync and command line
  input wire logic sync_comm_line_i,
  output logic sync_tick_o,
  // Group fault lines, open drain
  input wire logic [GROUPS-1:0] group_ok_i,
  output logic [GROUPS-1:0] group_ok_o,
  output logic [GROUPS-1:0] group_ok_oe_o,
  // Configuration
  input wire logic [`FIR_ADDR_W-1:0] unit_addr_i,
  input wire logic [$clog2(GROUPS)-1:0] group_sel_i,
  input wire logic [N_FAULT-1:0] latch_cfg_i,
  input wire logic [2*N_FAULT-1:0] prop_cfg_i,
  // Converter side
  input wire logic enable_pin_i,
  input wire logic [N_FAULT-1:0] fault_det_i,
  output logic output_on_o,
  output logic [N_FAULT-1:0] fault_active_o,
  output logic latched_o,
  output logic hiccup_o,
  output logic group_hold_o
);
  // Propagation scope of all triggered faults, bit 0 group and bit 1 system
  function automatic logic [1:0] scope_of(input logic [N_FAULT-1:0] trig,
                                          input logic [2*N_FAULT-1:0] cfg);
    logic [1:0] acc;
    acc = 2'h0;
    for (int i = 0; i < N_FAULT; i++) begin
      if (trig[i]) begin
        acc = acc | cfg[2*i +: 2];
      end
    end
    return acc;
  endfunction

  // States in which this unit still owns a fault
  function automatic logic faulted(input fir_pkg::fir_state_e s);
    return (s == fir_pkg::FIR_ST_FAULT) ||
           (s == fir_pkg::FIR_ST_HICCUP) ||
           (s == fir_pkg::FIR_ST_LATCHED);
  endfunction

  // Command receiver
  logic cmd_valid;
  logic [`FIR_FRAME_BITS-1:0] cmd_frame;

  fir_sync_cmd_rx #(
    .SYNC_MIN(SYNC_MIN),
    .BIT_CYCLES(BIT_CYCLES),
    .FRAME_BITS(`FIR_FRAME_BITS)
  ) u_rx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .line_i(sync_comm_line_i),
    .sync_tick_o(sync_tick_o),
    .cmd_valid_o(cmd_valid),
    .cmd_frame_o(cmd_frame)
  );

  wire [`FIR_ADDR_W-1:0] cmd_addr = cmd_frame[`FIR_ADDR_LSB +: `FIR_ADDR_W];
  wire [`FIR_OP_W-1:0] cmd_op = cmd_frame[`FIR_OP_LSB +: `FIR_OP_W];
  wire [`FIR_ARG_W-1:0] cmd_arg = cmd_frame[`FIR_ARG_LSB +: `FIR_ARG_W];
  wire cmd_mine = cmd_valid && (cmd_addr == unit_addr_i);
  wire cmd_on = cmd_mine && (cmd_op == fir_pkg::FIR_OP_ON);
  wire cmd_off = cmd_mine && (cmd_op == fir_pkg::FIR_OP_OFF);
  wire cmd_inj_set = cmd_mine && (cmd_op == fir_pkg::FIR_OP_INJ_SET);
  wire cmd_inj_clr = cmd_mine && (cmd_op == fir_pkg::FIR_OP_INJ_CLR);

  // State
  fir_pkg::fir_state_e state_reg;
  fir_pkg::fir_state_e state_next;
  logic [N_FAULT-1:0] inj_reg;
  logic [N_FAULT-1:0] inj_next;
  logic [1:0] scope_reg;
  logic [1:0] scope_next;
  logic [CNT_W-1:0] hic_cnt_reg;
  logic [CNT_W-1:0] hic_cnt_next;
  logic run_req_reg;
  logic en_q_reg;
  logic [GROUPS-1:0] pull_next;
  logic on_next;

  // Injection request held until its clear command
  wire [N_FAULT-1:0] inj_bit = N_FAULT'(1) << cmd_arg;
  always_comb begin
    inj_next = inj_reg;
    if (cmd_inj_clr) begin
      inj_next = inj_next & ~inj_bit; // [RULE2]
    end
    if (cmd_inj_set) begin
      inj_next = inj_next | inj_bit; // [RULE2]
    end
  end

  // Injected and detected triggers share one path from here on
  wire [N_FAULT-1:0] trig = fault_det_i | inj_reg; // [RULE1]
  wire fault_hit = |trig;
  wire latch_hit = |(trig & latch_cfg_i);
  wire [1:0] trig_scope = scope_of(trig, prop_cfg_i);

  // Latched clear by enable toggle or off command
  wire en_fall = en_q_reg && !enable_pin_i;
  wire latch_clr = cmd_off || en_fall; // [RULE8]
  wire run_ok = run_req_reg && enable_pin_i && !cmd_off;
  wire hic_done = (hic_cnt_reg == '0);

  // Following a fault of the assigned group line that someone else pulls
  wire own_line_low = !group_ok_i[group_sel_i]; // [RULE10]
  wire own_pulling = group_ok_oe_o[group_sel_i];
  wire follow_hold = own_line_low && !own_pulling; // [RULE3]

  always_comb begin
    state_next = state_reg;
    hic_cnt_next = hic_cnt_reg;
    case (state_reg)
      fir_pkg::FIR_ST_OFF: begin
        if (latch_hit) begin
          state_next = fir_pkg::FIR_ST_LATCHED;
        end else if (fault_hit) begin
          state_next = fir_pkg::FIR_ST_FAULT;
        end else if (run_ok) begin
          state_next = fir_pkg::FIR_ST_RUN;
        end
      end
      fir_pkg::FIR_ST_RUN: begin
        if (latch_hit) begin
          state_next = fir_pkg::FIR_ST_LATCHED; // [RULE3]
        end else if (fault_hit) begin
          state_next = fir_pkg::FIR_ST_FAULT; // [RULE3]
        end else if (!run_ok) begin
          state_next = fir_pkg::FIR_ST_OFF;
        end
      end
      fir_pkg::FIR_ST_FAULT: begin
        if (latch_hit) begin
          state_next = fir_pkg::FIR_ST_LATCHED;
        end else if (!fault_hit) begin
          state_next = fir_pkg::FIR_ST_HICCUP; // [RULE4]
          hic_cnt_next = CNT_W'(HICCUP_CYCLES - 1); // [RULE5]
        end
      end
      fir_pkg::FIR_ST_HICCUP: begin
        if (latch_hit) begin
          state_next = fir_pkg::FIR_ST_LATCHED;
        end else if (fault_hit) begin
          state_next = fir_pkg::FIR_ST_FAULT;
        end else if (hic_done) begin
          // Auto restart needs no command, only the standing run request and a high enable pin
          state_next = run_ok ? fir_pkg::FIR_ST_RUN : fir_pkg::FIR_ST_OFF; // [RULE5]
        end else begin
          hic_cnt_next = hic_cnt_reg - CNT_W'(1); // [RULE5]
        end
      end
      fir_pkg::FIR_ST_LATCHED: begin
        // Trigger removal alone changes nothing here
        if (latch_clr) begin
          state_next = fir_pkg::FIR_ST_OFF; // [RULE8] [RULE7]
        end
      end
      default: begin
        state_next = fir_pkg::FIR_ST_OFF;
      end
    endcase
  end

  // Scope gathers while faulted, holds through hiccup and latch
  wire st_next_faulted = faulted(state_next);
  wire st_faulted = faulted(state_reg);

  always_comb begin
    scope_next = `FIR_SCOPE_RST;
    if (st_next_faulted) begin
      scope_next = (st_faulted ? scope_reg : `FIR_SCOPE_RST) | trig_scope; // [RULE3]
    end
  end

  // Pull held through hiccup, so followers restart when the source does
  always_comb begin
    pull_next = '0;
    if (st_next_faulted) begin
      if (scope_next[1]) begin
        pull_next = '1; // [RULE3] [RULE6]
      end else if (scope_next[0]) begin
        pull_next[group_sel_i] = 1'b1; // [RULE3] [RULE10] [RULE11]
      end
    end
  end

  // Output on only in run with no group fault held by another unit
  always_comb begin
    on_next = (state_next == fir_pkg::FIR_ST_RUN) && !follow_hold; // [RULE6]
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= fir_pkg::FIR_ST_OFF;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inj_reg <= `FIR_INJ_RST;
    end else if (ce_i) begin
      inj_reg <= inj_next; // [RULE2]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scope_reg <= `FIR_SCOPE_RST;
    end else if (ce_i) begin
      scope_reg <= scope_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hic_cnt_reg <= '0;
    end else if (ce_i) begin
      hic_cnt_reg <= hic_cnt_next;
    end
  end

  // Off wins over on; one frame never carries both
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_req_reg <= 1'b0;
    end else if (ce_i) begin
      if (cmd_off) begin
        run_req_reg <= 1'b0; // [RULE8]
      end else if (cmd_on) begin
        run_req_reg <= 1'b1;
      end
    end
  end

  // Starts low so a pin already low at reset is no falling edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q_reg <= 1'b0;
    end else if (ce_i) begin
      en_q_reg <= enable_pin_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      group_ok_oe_o <= '0;
    end else if (ce_i) begin
      group_ok_oe_o <= pull_next; // [RULE3]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_on_o <= 1'b0;
    end else if (ce_i) begin
      output_on_o <= on_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_active_o <= '0;
    end else if (ce_i) begin
      fault_active_o <= trig; // [RULE1]
    end
  end

  // Status follows next state so it lines up with the output register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latched_o <= 1'b0;
      hiccup_o <= 1'b0;
    end else if (ce_i) begin
      latched_o <= (state_next == fir_pkg::FIR_ST_LATCHED);
      hiccup_o <= (state_next == fir_pkg::FIR_ST_HICCUP);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      group_hold_o <= 1'b0;
    end else if (ce_i) begin
      group_hold_o <= follow_hold;
    end
  end

  // Open drain: only ever drives low
  assign group_ok_o = '0;

endmodule // fir_fault_inject_recovery

`default_nettype wire

// ==== tb/fir_fault_inject_recovery_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module fir_fault_inject_recovery_sva #(
  parameter int unsigned N_FAULT = 4,
  parameter int unsigned GROUPS = 4,
  parameter int unsigned HICCUP_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic sync_tick_o,
  input wire logic [GROUPS-1:0] group_ok_oe_o,
  input wire logic [N_FAULT-1:0] fault_det_i,
  input wire logic output_on_o,
  input wire logic [N_FAULT-1:0] fault_active_o,
  input wire logic latched_o,
  input wire logic hiccup_o,
  input wire logic group_hold_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Length of the current hiccup run
  logic [31:0] hcnt_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) hcnt_reg <= 32'h0;
    else hcnt_reg <= hiccup_o ? hcnt_reg + 32'h1 : 32'h0;
  end
  chk_tick_one: assert property (sync_tick_o |=> !sync_tick_o)
    else $error("sync tick longer than one cycle");
  chk_det_seen: assert property (fault_det_i != '0 |=>
    (fault_active_o & $past(fault_det_i)) == $past(fault_det_i))
    else $error("detected fault not in trigger vector");
  chk_fault_off: assert property (fault_active_o != '0 |-> !output_on_o)
    else $error("output on during fault");
  chk_latch_off: assert property (latched_o |-> !output_on_o && !hiccup_o)
    else $error("latched unit runs or hiccups");
  chk_hiccup_clr: assert property (hiccup_o |-> !output_on_o && fault_active_o == '0)
    else $error("hiccup with trigger or output on");
  chk_hiccup_len: assert property (($rose(output_on_o) && $past(hiccup_o)) |->
    hcnt_reg >= HICCUP_CYCLES - 1 && hcnt_reg <= HICCUP_CYCLES + 2)
    else $error("hiccup length wrong");
  chk_oe_cause: assert property (group_ok_oe_o != '0 |->
    (fault_active_o != '0 || latched_o || hiccup_o))
    else $error("group line pulled without fault");
  chk_follow_off: assert property (group_hold_o |-> !output_on_o)
    else $error("follower output on");
  cover property ($rose(hiccup_o));
  cover property ($rose(latched_o));
  cover property ($rose(group_hold_o));
endmodule // fir_fault_inject_recovery_sva
`default_nettype wire

// ==== tb/fir_pm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fir_pm_model #(
  parameter int unsigned SYNC_MIN = 8,
  parameter int unsigned BIT_CYCLES = 4
) (
  // Clock
  input wire logic clk_i,
  // Shared line and group lines
  output logic line_o,
  input wire logic [3:0] group_ok_i,
  output logic fault_seen_o
);
  // Any low group line is a fault, polling or not
  assign fault_seen_o = ~&group_ok_i;
  initial line_o = 1'b1;
  // Sync run, then ten cells MSB first, all on one line
  task automatic send(input logic [4:0] addr, input logic [2:0] op, input logic [1:0] idx);
    logic [9:0] frame;
    frame = {addr, op, idx};
    @(negedge clk_i);
    line_o = 1'b0;
    repeat (SYNC_MIN + 2) @(negedge clk_i);
    line_o = 1'b1;
    @(negedge clk_i);
    for (int k = 9; k >= 0; k--) begin
      line_o = frame[k];
      repeat (BIT_CYCLES) @(negedge clk_i);
    end
    line_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
endmodule // fir_pm_model
`default_nettype wire

// ==== tb/fir_fault_inject_recovery_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module fir_fault_inject_recovery_tb_top;
  localparam int unsigned HC = 20;
  localparam logic [4:0] ME = 5'h05;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic line, tick, hold, on, lat, hic, seen;
  logic en = 1'b1;
  logic [1:0] gsel = 2'h0;
  logic [3:0] latch_cfg = 4'h0;
  logic [3:0] det = 4'h0;
  logic [3:0] pull = 4'h0;
  logic [3:0] oe, fa, okv;
  logic [7:0] prop_cfg = 8'h55;
  logic [15:0] rnd = 16'h0021;
  int fails = 0;
  int check_count = 0;
  int ticks = 0;
  // Open-drain group lines with pull-ups
  wire logic [3:0] grp = ~(oe | pull);
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (tick === 1'b1) ticks++;
  fir_fault_inject_recovery #(.HICCUP_CYCLES(HC), .SYNC_MIN(8), .BIT_CYCLES(4)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .sync_comm_line_i(line),
    .sync_tick_o(tick), .group_ok_i(grp), .group_ok_o(okv), .group_ok_oe_o(oe),
    .unit_addr_i(ME), .group_sel_i(gsel), .latch_cfg_i(latch_cfg), .prop_cfg_i(prop_cfg),
    .enable_pin_i(en), .fault_det_i(det), .output_on_o(on), .fault_active_o(fa),
    .latched_o(lat), .hiccup_o(hic), .group_hold_o(hold));
  fir_pm_model #(.SYNC_MIN(8), .BIT_CYCLES(4)) u_pm (
    .clk_i(clk_i), .line_o(line), .group_ok_i(grp), .fault_seen_o(seen));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic cmd(input fir_pkg::fir_op_e op, input logic [1:0] idx);
    u_pm.send(ME, op, idx);
  endtask
  // Bounded wait for the output, returns the cycles spent
  task automatic wait_on(output int n);
    for (n = 0; n < 100 && on !== 1'b1; n++) @(negedge clk_i);
    if (on !== 1'b1) begin
      fails++;
      $display("ERROR %0t output never came on", $time);
      give_verdict();
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    int n;
    cyc(12);
    rstn_i = 1'b1;
    chk(on === 1'b0 && oe === 4'h0 && lat === 1'b0, "reset state");
    chk(okv === 4'h0, "group line driven high");
    u_pm.send(5'h1A, fir_pkg::FIR_OP_ON, 2'h0);
    chk(on === 1'b0, "foreign address obeyed");
    cmd(fir_pkg::FIR_OP_ON, 2'h0);
    wait_on(n);
    chk(ticks == 2, "sync count");
    $display("test line done");
    for (int f = 0; f < 4; f++) begin
      rnd = lfsr(rnd);
      gsel = rnd[1:0];
      cmd(fir_pkg::FIR_OP_INJ_SET, f[1:0]);
      cyc(2 * HC);
      chk(fa === 4'(1 << f) && on === 1'b0, "injection not held");
      chk(oe === 4'(1 << gsel) && seen === 1'b1, "group pull");
      cmd(fir_pkg::FIR_OP_INJ_CLR, f[1:0]);
      chk(hic === 1'b1 && fa === 4'h0, "no hiccup after clear");
      wait_on(n);
      chk(n >= HC - 10 && n <= HC, "hiccup time");
    end
    $display("test inject done");
    latch_cfg = 4'h8;
    prop_cfg = 8'h80;
    det = 4'h8;
    cyc(3);
    chk(lat === 1'b1 && oe === 4'hF && on === 1'b0, "latch");
    det = 4'h0;
    cyc(2 * HC);
    chk(lat === 1'b1 && on === 1'b0, "latch let go");
    cmd(fir_pkg::FIR_OP_OFF, 2'h0);
    chk(lat === 1'b0 && on === 1'b0, "off did not clear");
    cmd(fir_pkg::FIR_OP_ON, 2'h0);
    wait_on(n);
    det = 4'h8;
    cyc(3);
    det = 4'h0;
    chk(lat === 1'b1, "no relatch");
    en = 1'b0;
    cyc(3);
    en = 1'b1;
    cyc(3);
    chk(lat === 1'b0, "enable toggle did not clear");
    cmd(fir_pkg::FIR_OP_ON, 2'h0);
    wait_on(n);
    $display("test latch done");
    latch_cfg = 4'h0;
    pull = 4'(1 << (gsel + 2'h1));
    cyc(6);
    chk(on === 1'b1 && hold === 1'b0, "foreign group followed");
    pull = 4'(1 << gsel);
    cyc(3);
    chk(hold === 1'b1 && on === 1'b0, "group not followed");
    pull = 4'h0;
    wait_on(n);
    $display("test follow done");
    prop_cfg = 8'h00;
    det = 4'h1;
    cyc(3);
    chk(fa === 4'h1 && oe === 4'h0 && on === 1'b0 && seen === 1'b0, "scope none");
    det = 4'h0;
    wait_on(n);
    chk(n >= HC && n <= HC + 2, "hiccup after detected fault");
    $display("test scope done");
    give_verdict();
  end
endmodule // fir_fault_inject_recovery_tb_top
bind fir_fault_inject_recovery fir_fault_inject_recovery_sva #(.N_FAULT(N_FAULT),
  .GROUPS(GROUPS), .HICCUP_CYCLES(HICCUP_CYCLES)) u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
  .sync_tick_o(sync_tick_o), .group_ok_oe_o(group_ok_oe_o), .fault_det_i(fault_det_i),
  .output_on_o(output_on_o), .fault_active_o(fault_active_o), .latched_o(latched_o),
  .hiccup_o(hiccup_o), .group_hold_o(group_hold_o));
`default_nettype wire
